// [logic/mds_defines.vh]
// register offsets, control field positions and widths for the mac slice
`ifndef MDS_DEFINES_VH
`define MDS_DEFINES_VH
`define MDS_OFF_CTRL       8'h00
`define MDS_OFF_PAT_LO     8'h04
`define MDS_OFF_PAT_HI     8'h08
`define MDS_OFF_MASK_LO    8'h0C
`define MDS_OFF_MASK_HI    8'h10
`define MDS_OFF_RES_LO     8'h14
`define MDS_OFF_RES_HI     8'h18
`define MDS_CTRL_RESET     32'h00000000
`define MDS_CTRL_WMASK     32'h07FFFFFF
`define MDS_PAT_RESET      48'h000000000000
`define MDS_MASK_RESET     48'h000000000000
`define MDS_F_SUB          0
`define MDS_F_LOGIC        1
`define MDS_F_FUNC_LO      2
`define MDS_F_FUNC_HI      5
`define MDS_F_SIMD_LO      6
`define MDS_F_SIMD_HI      7
`define MDS_F_BYPASS       8
`define MDS_F_PRE_EN       9
`define MDS_F_PRE_SUB      10
`define MDS_F_YSEL_LO      11
`define MDS_F_YSEL_HI      12
`define MDS_F_COUNT        13
`define MDS_F_ROUND        14
`define MDS_F_RPOS_LO      15
`define MDS_F_RPOS_HI      20
`define MDS_F_AREG         21
`define MDS_F_BREG         22
`define MDS_F_CREG         23
`define MDS_F_DREG         24
`define MDS_F_MREG         25
`define MDS_F_ACASC        26
`define MDS_SIMD_ONE48     2'h0
`define MDS_SIMD_TWO24     2'h1
`define MDS_SIMD_FOUR12    2'h2
`define MDS_YSEL_ZERO      2'h0
`define MDS_YSEL_C         2'h1
`define MDS_YSEL_ACC       2'h2
`define MDS_YSEL_CASC      2'h3
`define MDS_FN_AND         4'h0
`define MDS_FN_OR          4'h1
`define MDS_FN_XOR         4'h2
`define MDS_FN_XNOR        4'h3
`define MDS_FN_NAND        4'h4
`define MDS_FN_NOR         4'h5
`define MDS_FN_X_ANDN_Y    4'h6
`define MDS_FN_X_ORN_Y     4'h7
`define MDS_FN_NX_AND_Y    4'h8
`define MDS_FN_NX_OR_Y     4'h9
`define MDS_LANE_W         12
`define MDS_LANES          4
`endif

// [logic/mds_lane.v]
// one carry-linked adder lane of the simd arithmetic unit
`timescale 1ns/1ps
module mds_lane #(
  parameter W = 12
) (
  input  wire [W-1:0] x,
  input  wire [W-1:0] y,
  input  wire         cin,
  output wire [W-1:0] sum,
  output wire         cout
);
  wire [W:0] total;

  assign total = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, cin};
  assign sum   = total[W-1:0];
  assign cout  = total[W];
endmodule

// [logic/mds_slice.v]
// multiply-accumulate slice with simd alu, logic unit, pattern detector and apb control
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "mds_defines.vh"
module mds_slice (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ce,
  input  wire [24:0] a_in,
  input  wire [24:0] d_in,
  input  wire [17:0] b_in,
  input  wire [47:0] c_in,
  input  wire [47:0] x_in,
  input  wire [24:0] acin,
  input  wire [47:0] pcin,
  output reg  [24:0] acout,
  output reg  [47:0] p_out,
  output reg  [47:0] pcout,
  output reg  [3:0]  carry_out,
  output reg         pat_match,
  output reg         pat_match_inv
);
  localparam NL = `MDS_LANES;
  localparam LW = `MDS_LANE_W;

  reg  [31:0] ctrl_reg;
  reg  [47:0] pat_reg;
  reg  [47:0] mask_reg;
  reg  [24:0] a_reg;
  reg  [24:0] d_reg;
  reg  [17:0] b_reg;
  reg  [47:0] c_reg;
  reg  [47:0] m_reg;
  reg  [47:0] acc_reg;
  reg  [31:0] rdata_next;
  reg         rerr_next;
  reg  [47:0] lu_out;
  reg  [47:0] y_src;

  wire        op_sub    = ctrl_reg[`MDS_F_SUB];
  wire        logic_md  = ctrl_reg[`MDS_F_LOGIC];
  wire [3:0]  func      = ctrl_reg[`MDS_F_FUNC_HI:`MDS_F_FUNC_LO];
  wire [1:0]  simd      = ctrl_reg[`MDS_F_SIMD_HI:`MDS_F_SIMD_LO];
  wire        bypass    = ctrl_reg[`MDS_F_BYPASS];
  wire        pre_en    = ctrl_reg[`MDS_F_PRE_EN];
  wire        pre_sub   = ctrl_reg[`MDS_F_PRE_SUB];
  wire [1:0]  ysel      = ctrl_reg[`MDS_F_YSEL_HI:`MDS_F_YSEL_LO];
  wire        count_md  = ctrl_reg[`MDS_F_COUNT];
  wire        round_md  = ctrl_reg[`MDS_F_ROUND];
  wire [5:0]  rpos      = ctrl_reg[`MDS_F_RPOS_HI:`MDS_F_RPOS_LO];
  wire        areg_en   = ctrl_reg[`MDS_F_AREG];
  wire        breg_en   = ctrl_reg[`MDS_F_BREG];
  wire        creg_en   = ctrl_reg[`MDS_F_CREG];
  wire        dreg_en   = ctrl_reg[`MDS_F_DREG];
  wire        mreg_en   = ctrl_reg[`MDS_F_MREG];
  wire        acasc     = ctrl_reg[`MDS_F_ACASC];

  // apb access phase completes on the edge where pready is already high
  wire        wr_fire   = psel & penable & pready & pwrite;

  // operand selection and optional input registers
  wire [24:0] a_src     = acasc ? acin : a_in;
  wire [24:0] a_use     = areg_en ? a_reg : a_src;
  wire [24:0] d_use     = dreg_en ? d_reg : d_in;
  wire [17:0] b_use     = breg_en ? b_reg : b_in;
  wire [47:0] c_use     = creg_en ? c_reg : c_in;

  wire [24:0] pre_sum   = pre_sub ? (d_use - a_use) : (d_use + a_use);
  wire [24:0] mul_a     = pre_en ? pre_sum : a_use;
  wire [42:0] prod      = $signed(mul_a) * $signed(b_use);
  wire [47:0] prod_ext  = {{5{prod[42]}}, prod};
  wire [47:0] m_use     = mreg_en ? m_reg : prod_ext;

  wire [47:0] x_opd     = count_md ? acc_reg : (bypass ? x_in : m_use);
  wire [47:0] y_opd     = count_md ? 48'h000000000001 : y_src;
  wire [47:0] y_eff     = op_sub ? ~y_opd : y_opd;

  wire [47:0] sum;
  wire [NL-1:0] lcout;
  wire [NL-1:0] lcin;

  always @* begin
    case (ysel)
      `MDS_YSEL_ZERO: y_src = 48'h000000000000;
      `MDS_YSEL_C:    y_src = c_use;
      `MDS_YSEL_ACC:  y_src = acc_reg;
      `MDS_YSEL_CASC: y_src = pcin;
      default:        y_src = 48'h000000000000;
    endcase
  end

  // lanes restart the carry with the subtract bit at each simd boundary
  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : lane
      wire brk = (g == 0) || (simd == `MDS_SIMD_FOUR12) || ((simd == `MDS_SIMD_TWO24) && (g == 2));
      assign lcin[g] = brk ? op_sub : ((g == 0) ? 1'b0 : lcout[(g == 0) ? 0 : g - 1]);
      mds_lane #(.W(LW)) u_lane (
        .x    (x_opd[g*LW +: LW]),
        .y    (y_eff[g*LW +: LW]),
        .cin  (lcin[g]),
        .sum  (sum[g*LW +: LW]),
        .cout (lcout[g])
      );
    end
  endgenerate

  always @* begin
    case (func)
      `MDS_FN_AND:      lu_out = x_opd & y_opd;
      `MDS_FN_OR:       lu_out = x_opd | y_opd;
      `MDS_FN_XOR:      lu_out = x_opd ^ y_opd;
      `MDS_FN_XNOR:     lu_out = ~(x_opd ^ y_opd);
      `MDS_FN_NAND:     lu_out = ~(x_opd & y_opd);
      `MDS_FN_NOR:      lu_out = ~(x_opd | y_opd);
      `MDS_FN_X_ANDN_Y: lu_out = x_opd & ~y_opd;
      `MDS_FN_X_ORN_Y:  lu_out = x_opd | ~y_opd;
      `MDS_FN_NX_AND_Y: lu_out = ~x_opd & y_opd;
      `MDS_FN_NX_OR_Y:  lu_out = ~x_opd | y_opd;
      default:          lu_out = 48'h000000000000;
    endcase
  end

  wire        alu_logic = logic_md & ~count_md;
  wire [47:0] alu_res   = alu_logic ? lu_out : sum;

  // detector looks at the new result before rounding, so on the logic unit it compares the 48-bit logic output
  wire [47:0] diff      = (alu_res ^ pat_reg) & ~mask_reg;
  wire [47:0] diff_inv  = (alu_res ^ ~pat_reg) & ~mask_reg;
  wire        hit       = (diff == 48'h000000000000);
  wire        hit_inv   = (diff_inv == 48'h000000000000);

  // convergent rounding: a tie seen by the detector forces the round bit to even
  wire [47:0] rbit      = 48'h000000000001 << rpos;
  wire [47:0] res_fin   = (round_md && hit) ? (alu_res & ~rbit) : alu_res;

  wire [3:0]  lane_cy   = op_sub ? ~lcout : lcout;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_reg         <= 25'h0000000;
      d_reg         <= 25'h0000000;
      b_reg         <= 18'h00000;
      c_reg         <= 48'h000000000000;
      m_reg         <= 48'h000000000000;
      acc_reg       <= 48'h000000000000;
      acout         <= 25'h0000000;
      p_out         <= 48'h000000000000;
      pcout         <= 48'h000000000000;
      carry_out     <= 4'h0;
      pat_match     <= 1'b0;
      pat_match_inv <= 1'b0;
    end else if (ce) begin
      a_reg         <= a_src;
      d_reg         <= d_in;
      b_reg         <= b_in;
      c_reg         <= c_in;
      m_reg         <= prod_ext;
      acc_reg       <= res_fin;
      acout         <= a_use;
      p_out         <= res_fin;
      pcout         <= res_fin;
      carry_out     <= alu_logic ? 4'h0 : lane_cy;
      pat_match     <= hit;
      pat_match_inv <= hit_inv;
    end
  end

  // register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `MDS_CTRL_RESET;
      pat_reg  <= `MDS_PAT_RESET;
      mask_reg <= `MDS_MASK_RESET;
    end else if (wr_fire) begin
      case (paddr)
        `MDS_OFF_CTRL:    ctrl_reg         <= pwdata & `MDS_CTRL_WMASK;
        `MDS_OFF_PAT_LO:  pat_reg[31:0]    <= pwdata;
        `MDS_OFF_PAT_HI:  pat_reg[47:32]   <= pwdata[15:0];
        `MDS_OFF_MASK_LO: mask_reg[31:0]   <= pwdata;
        `MDS_OFF_MASK_HI: mask_reg[47:32]  <= pwdata[15:0];
        default:          ctrl_reg         <= ctrl_reg;
      endcase
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    rerr_next  = 1'b0;
    case (paddr)
      `MDS_OFF_CTRL:    rdata_next = ctrl_reg;
      `MDS_OFF_PAT_LO:  rdata_next = pat_reg[31:0];
      `MDS_OFF_PAT_HI:  rdata_next = {16'h0000, pat_reg[47:32]};
      `MDS_OFF_MASK_LO: rdata_next = mask_reg[31:0];
      `MDS_OFF_MASK_HI: rdata_next = {16'h0000, mask_reg[47:32]};
      `MDS_OFF_RES_LO:  rdata_next = p_out[31:0];
      `MDS_OFF_RES_HI:  rdata_next = {10'h000, carry_out, pat_match_inv, pat_match, p_out[47:32]};
      default:          rerr_next  = 1'b1;
    endcase
    if (pwrite && (paddr == `MDS_OFF_RES_LO || paddr == `MDS_OFF_RES_HI)) begin
      rerr_next = 1'b1;
    end
  end

  // answer prepared in the setup cycle, so the access phase never waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h00000000 : rdata_next;
      pready  <= 1'b1;
      pslverr <= rerr_next;
    end else begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// [tb/mds_fabric.sv]
// fabric model that drives the slice operands
`timescale 1ns/1ps
module mds_fabric (
  input  wire        pclk,
  input  wire        step,
  output reg  [24:0] a_in,
  output reg  [24:0] d_in,
  output reg  [17:0] b_in,
  output reg  [47:0] c_in,
  output reg  [47:0] x_in,
  output reg  [24:0] acin,
  output reg  [47:0] pcin
);
  initial {a_in, d_in, b_in, c_in, x_in, pcin, acin} = 237'h0;
  // operands only move on request, held stable otherwise
  always @(posedge pclk) begin
    if (step) begin
      a_in <= 25'($urandom);
      d_in <= 25'($urandom);
      b_in <= 18'($urandom);
      c_in <= {16'($urandom), $urandom};
      x_in <= {16'($urandom), $urandom};
      pcin <= {16'($urandom), $urandom};
      acin <= 25'($urandom);
    end
  end
endmodule

// [tb/mds_slice_asserts.sv]
// concurrent checks on the slice ports
`timescale 1ns/1ps
module mds_slice_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        ce,
  input wire [24:0] a_in,
  input wire [17:0] b_in,
  input wire [47:0] c_in,
  input wire [47:0] x_in,
  input wire [24:0] acin,
  input wire [47:0] pcin,
  input wire [24:0] acout,
  input wire [47:0] p_out,
  input wire [47:0] pcout
);
  reg  [31:0] ctrl_sh;
  wire [47:0] prod = 48'($signed(a_in) * $signed(b_in));
  // copy of the control word as written over the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_sh <= 32'h0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00) ctrl_sh <= pwdata & 32'h07FFFFFF;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence two_ce;
    ce && ctrl_sh == 32'h02000800 ##1 ce;
  endsequence
  rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
  rdy_single_a: assert property (pready |=> !pready) else $error("ready too long");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
  res_ro_a: assert property (pready && pwrite && paddr == 8'h14 |-> pslverr) else $error("no error");
  hold_ce_a: assert property (!ce |=> $stable(p_out)) else $error("result moved");
  cascade_out_a: assert property (pcout == p_out) else $error("cascade differs");
  casc_in_a: assert property (ce && ctrl_sh == 32'h1900 |=> pcout == $past(x_in + pcin))
    else $error("cascade in");
  acout_fwd_a: assert property (ce && !ctrl_sh[21] |=> acout == $past(ctrl_sh[26] ? acin : a_in))
    else $error("acout");
  mult_acc_a: assert property (ce && ctrl_sh == 32'h800 |=> p_out == $past(prod + c_in))
    else $error("mult");
  bypass_x_a: assert property (ce && ctrl_sh == 32'h100 |=> p_out == $past(x_in)) else $error("bypass");
  logic_xor_a: assert property (ce && ctrl_sh == 32'h90A |=> p_out == $past(x_in ^ c_in))
    else $error("xor");
  count_up_a: assert property (ce && ctrl_sh == 32'h2000 |=> p_out == $past(p_out) + 48'h1)
    else $error("count");
  mreg_lat_a: assert property (two_ce |=> p_out == $past(prod, 2) + $past(c_in)) else $error("mreg");
endmodule
bind mds_slice mds_slice_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .ce, .a_in, .b_in, .c_in, .x_in, .acin, .pcin, .acout, .p_out, .pcout);

// [tb/tb_mds_slice.sv]
// self-checking bench for the mac slice
`timescale 1ns/1ps
module tb_mds_slice;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 0, step = 0, er;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [47:0] acc = 48'h0, e, pat = 48'h0;
  reg  [3:0]  ecy, evm;
  wire [31:0] prdata;
  wire [24:0] a_in, d_in, acout, acin;
  wire [17:0] b_in;
  wire [47:0] c_in, x_in, pcin, p_out, pcout;
  wire [3:0]  carry_out;
  wire        pready, pslverr, pat_match, pat_match_inv;
  integer     mismatches = 0, n_checks = 0, i, k;
  always #25 pclk = ~pclk;
  mds_fabric u_fab (.pclk, .step, .a_in, .d_in, .b_in, .c_in, .x_in, .acin, .pcin);
  mds_slice u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ce, .a_in, .d_in, .b_in, .c_in, .x_in, .acin, .pcin, .acout, .p_out, .pcout,
    .carry_out, .pat_match, .pat_match_inv);
  task chk(input [47:0] g, input [47:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("Error %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] ad, input [31:0] wd);
    integer n;
    begin
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task rchk(input [7:0] ad, input [47:0] x, input xe);
    begin
      apb(1'b0, ad, 32'h0);
      chk({16'h0, rd}, x);
      chk({47'h0, er}, {47'h0, xe});
    end
  endtask
  function [47:0] mdl(input [31:0] t);
    reg [24:0] pa, av;
    reg [47:0] xo, yo, r, q;
    reg [48:0] mk, cy;
    integer w, j;
    begin
      av = t[26] ? acin : a_in;
      pa = t[9] ? (t[10] ? d_in - av : d_in + av) : av;
      q = $signed(pa) * $signed(b_in);
      xo = t[13] ? acc : t[8] ? x_in : q;
      yo = t[13] ? 48'h1 : t[12:11] == 2'h0 ? 48'h0 : t[12:11] == 2'h1 ? c_in : t[12:11] == 2'h2 ? acc : pcin;
      w = t[7:6] == 2'h1 ? 24 : t[7:6] == 2'h2 ? 12 : 48;
      r = 48'h0;
      ecy = 4'h0;
      evm = w == 48 ? 4'h8 : w == 24 ? 4'hA : 4'hF;
      mk = (49'h1 << w) - 49'h1;
      if (t[1] && !t[13]) begin
        case (t[5:2])
          4'h0: r = xo & yo;
          4'h1: r = xo | yo;
          4'h2: r = xo ^ yo;
          4'h3: r = ~(xo ^ yo);
          4'h4: r = ~(xo & yo);
          4'h5: r = ~(xo | yo);
          4'h6: r = xo & ~yo;
          4'h7: r = xo | ~yo;
          4'h8: r = ~xo & yo;
          4'h9: r = ~xo | yo;
          default: r = 48'h0;
        endcase
      end else begin
        for (j = 0; j < 48; j = j + w) begin
          q = (xo >> j) + (t[0] ? ~(yo >> j) + 48'h1 : yo >> j);
          r = r | ((q & ((48'h1 << w) - 48'h1)) << j);
          // lane carry out, a subtract reports the inverted carry
          cy = ((xo >> j) & mk) + ((t[0] ? ~(yo >> j) : yo >> j) & mk) + t[0];
          ecy[(j + w) / 12 - 1] = t[0] ^ cy[w];
        end
      end
      if (t[14] && r === pat) r[t[20:15]] = 1'b0;
      mdl = r;
    end
  endfunction
  // program, optionally renew operands, then clock n enabled edges
  task op(input [31:0] t, input integer n, input s);
    begin
      apb(1'b1, 8'h00, t);
      @(posedge pclk);
      step <= s;
      @(posedge pclk);
      step <= 1'b0;
      ce <= 1'b1;
      repeat (n) @(posedge pclk);
      ce <= 1'b0;
      e = mdl(t);
      #1;
      chk(p_out, e);
      chk(pcout, e);
      chk({44'h0, carry_out & evm}, {44'h0, ecy});
      chk({23'h0, acout}, {23'h0, t[26] ? acin : a_in});
      acc = e;
    end
  endtask
  initial begin
    rd = $urandom(32'hBDC9);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 20; i = i + 4) rchk(8'(i), 48'h0, 1'b0);
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    rchk(8'h00, 48'h07FFFFFF, 1'b0);
    rchk(8'h1C, 48'h0, 1'b1);
    apb(1'b1, 8'h14, 32'h1);
    chk({47'h0, er}, 48'h1);
    for (i = 0; i < 6; i = i + 1) op(32'h800, 1, 1'b1);
    op(32'h100, 1, 1'b1);
    for (i = 0; i < 3; i = i + 1) for (k = 0; k < 2; k = k + 1) op(32'h900 | i << 6 | k, 1, 1'b1);
    op(32'h1900, 1, 1'b1);
    for (i = 0; i < 10; i = i + 1) op(32'h902 | i << 2, 1, 1'b1);
    op(32'hA00, 1, 1'b1);
    op(32'hE00, 1, 1'b1);
    for (i = 0; i < 3; i = i + 1) op(32'h1000 | i << 6, 1, 1'b1);
    for (i = 0; i < 8; i = i + 1) op(32'h2000 | i / 4, 1, 1'b0);
    op(32'h02000800, 2, 1'b1);
    op(32'h01E00A00, 2, 1'b1);
    op(32'h04000800, 1, 1'b1);
    op(32'h90A, 1, 1'b1);
    pat = e;
    apb(1'b1, 8'h04, pat[31:0]);
    apb(1'b1, 8'h08, {16'h0, pat[47:32]});
    op(32'h90A, 1, 1'b0);
    chk({47'h0, pat_match}, 48'h1);
    chk({47'h0, pat_match_inv}, 48'h0);
    rchk(8'h14, {16'h0, pat[31:0]}, 1'b0);
    rchk(8'h18, {26'h0, 6'h01, pat[47:32]}, 1'b0);
    op(32'h490A, 1, 1'b0);
    chk({47'h0, pat_match}, 48'h1);
    // reset again in mid-run, then the accumulator starts from zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc = 48'h0;
    chk(p_out, 48'h0);
    rchk(8'h00, 48'h0, 1'b0);
    op(32'h1000, 1, 1'b1);
    report_and_stop;
  end
endmodule
